// *** bench/feeder_control_param_access_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module feeder_control_param_access_tb
  import feeder_param_pkg::*;
;
  localparam int NV_SIM = 10;
  logic clk_sys, reset, cmd_valid, ev_valid, auto_reset_seen;
  logic btn_step, btn_up, display_on, nv_fail, rsp_valid, rsp_error;
  logic rsp_empty, nv_busy, default_reload_inhibit, defaults_loaded;
  cmd_t cmd_op;
  logic [7:0] cmd_index;
  logic [15:0] cmd_wdata, rsp_data, rsp_time;
  logic [N_AR_CYCLES-1:0] ar_cycle_done;
  logic [1:0] ar_initiator;
  logic [4:0] ev_channel, rsp_channel;
  logic [5:0] ev_code, rsp_code;
  int error_cnt = 0;
  int comparisons = 0;

  // ----------------------------------------------------------
  // design and host model
  // ----------------------------------------------------------
  // short store and tick counts keep the run brief
  feeder_param_access #(.EV_DEPTH(2), .NV_CYCLES(NV_SIM),
    .TICK_CYCLES(4)) dut (
    .clk_sys, .reset, .cmd_valid, .cmd_op, .cmd_index, .cmd_wdata,
    .ar_cycle_done, .ar_initiator, .ev_valid, .ev_channel, .ev_code,
    .auto_reset_seen, .btn_step, .btn_up, .display_on, .nv_fail,
    .rsp_valid, .rsp_error, .rsp_empty, .rsp_data, .rsp_time,
    .rsp_channel, .rsp_code, .nv_busy, .default_reload_inhibit,
    .defaults_loaded);
  station_host host (.clk_sys, .cmd_valid, .cmd_op, .cmd_index,
    .cmd_wdata, .rsp_valid, .rsp_error, .rsp_empty, .rsp_data);

  // 25 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  task automatic chk16(input string n, input logic [15:0] e,
                       input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // every command is answered; refusal as expected
  task automatic cmd(input cmd_t op, input logic [7:0] i,
                     input logic [15:0] d, input logic err);
    host.send(op, i, d);
    chk1("answer", 1'b1, host.got_valid);
    chk1("refused", err, host.got_error);
  endtask
  task automatic rd(input cmd_t op, input logic [7:0] i,
                    input logic [15:0] e);
    cmd(op, i, 16'h0000, 1'b0);
    chk16("read data", e, host.got_data);
  endtask
  // the load pulse is short, so look after every edge
  task automatic wait_loaded;
    int n;
    for (n = 0; n < 4 && defaults_loaded !== 1'b1; n++) tick(1);
    chk1("defaults loaded", 1'b1, defaults_loaded);
  endtask
  task automatic ar_pulse(input int c, input logic [1:0] who);
    ar_cycle_done[c-1] = 1'b1;
    ar_initiator = who;
    tick(1);
    ar_cycle_done = '0;
    ar_initiator = 2'd3;
  endtask

  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_power;
    btn_step = 1'b1;
    btn_up = 1'b1;
    display_on = 1'b1;
    wait_loaded();
    btn_step = 1'b0;
    btn_up = 1'b0;
    chk1("inhibit pin", 1'b1, default_reload_inhibit);
    rd(CMD_PARAM_RD, IDX_INHIBIT, 16'h0001);
    rd(CMD_STAT_RD, 8'h00, 16'h0000);
    cmd(CMD_EV_REREAD, 8'h00, 16'h0000, 1'b0);
    chk1("reread empty", 1'b1, host.got_empty);
    $display("t_power done");
  endtask
  task automatic t_count;
    ar_pulse(1, 2'd3);
    rd(CMD_PARAM_RD, 8'h14, 16'h0001);
    rd(CMD_PARAM_RD, 8'h15, 16'h0000);
    ar_pulse(3, 2'd1);
    rd(CMD_PARAM_RD, 8'h1c, 16'h0001);
    rd(CMD_PARAM_RD, 8'h1e, 16'h0001);
    rd(CMD_PARAM_RD, 8'h1d, 16'h0000);
    cmd(CMD_PARAM_WR, 8'h1c, 16'h0005, 1'b1);
    cmd(CMD_PARAM_WR, 8'h1d, 16'h03e8, 1'b1);
    cmd(CMD_PARAM_WR, 8'h1d, CNT_MAX, 1'b0);
    ar_pulse(3, 2'd0);
    rd(CMD_PARAM_RD, 8'h1d, 16'h0000);
    rd(CMD_PARAM_RD, 8'h1c, 16'h0002);
    ar_pulse(5, 2'd2);
    rd(CMD_PARAM_RD, 8'h27, 16'h0001);
    rd(CMD_PARAM_RD, 8'h24, 16'h0001);
    $display("t_count done");
  endtask
  task automatic t_store;
    int n;
    cmd(CMD_PARAM_RD, IDX_NV_STORE, 16'h0000, 1'b1);
    cmd(CMD_PARAM_WR, IDX_NV_STORE, 16'h0002, 1'b1);
    cmd(CMD_PARAM_WR, IDX_NV_STORE, NV_STORE_GO, 1'b0);
    n = 0;
    if (nv_busy !== 1'b1) tick(1);
    while (nv_busy === 1'b1 && n < 40) begin
      n++;
      tick(1);
    end
    chk16("busy cycles", 16'(NV_SIM), 16'(n));
    cmd(CMD_PARAM_WR, IDX_NV_STORE, NV_STORE_GO, 1'b0);
    cmd(CMD_PARAM_WR, IDX_NV_STORE, NV_STORE_GO, 1'b1);
    tick(NV_SIM + 2);
    $display("t_store done");
  endtask
  task automatic t_inhibit;
    cmd(CMD_PARAM_WR, 8'h15, 16'h0007, 1'b0);
    cmd(CMD_PARAM_WR, IDX_INHIBIT, 16'h0002, 1'b1);
    cmd(CMD_PARAM_WR, IDX_INHIBIT, 16'h0000, 1'b0);
    cmd(CMD_PARAM_WR, IDX_NV_STORE, NV_STORE_GO, 1'b0);
    rd(CMD_PARAM_RD, IDX_INHIBIT, 16'h0000);
    chk1("inhibit pin", 1'b0, default_reload_inhibit);
    tick(NV_SIM + 2);
    nv_fail = 1'b1;
    tick(1);
    nv_fail = 1'b0;
    wait_loaded();
    rd(CMD_PARAM_RD, 8'h15, 16'h0000);
    chk1("inhibit pin", 1'b1, default_reload_inhibit);
    $display("t_inhibit done");
  endtask
  // depth two: the third event overflows the register
  task automatic t_events;
    int i;
    for (i = 1; i <= 3; i++) begin
      ev_valid = 1'b1;
      ev_channel = 5'(i);
      ev_code = 6'(i + 8);
      tick(1);
    end
    ev_valid = 1'b0;
    for (i = 1; i <= 2; i++) begin
      cmd(CMD_EV_READ, 8'h00, 16'h0000, 1'b0);
      chk1("event empty", 1'b0, host.got_empty);
      chk16("channel", 16'(i), 16'(rsp_channel));
      chk16("code", 16'(i + 8), 16'(rsp_code));
      chk1("stamp range", 1'b1, rsp_time <= TIME_MAX);
    end
    cmd(CMD_EV_READ, 8'h00, 16'h0000, 1'b0);
    chk1("event empty", 1'b1, host.got_empty);
    for (i = 0; i < 2; i++) begin
      cmd(CMD_EV_REREAD, 8'h00, 16'h0000, 1'b0);
      chk16("reread channel", 16'h0002, 16'(rsp_channel));
      chk16("reread code", 16'h000a, 16'(rsp_code));
    end
    rd(CMD_STAT_RD, 8'h00, 16'h0002);
    auto_reset_seen = 1'b1;
    tick(1);
    auto_reset_seen = 1'b0;
    rd(CMD_STAT_RD, 8'h00, 16'h0003);
    cmd(CMD_STAT_WR, 8'h00, 16'h0001, 1'b1);
    cmd(CMD_STAT_WR, 8'h00, STAT_CLEAR, 1'b0);
    rd(CMD_STAT_RD, 8'h00, 16'h0000);
    $display("t_events done");
  endtask
  task automatic t_time;
    cmd(CMD_TIME_WR, 8'h00, 16'hea60, 1'b1);
    cmd(CMD_TIME_WR, 8'h00, TIME_MAX, 1'b0);
    rd(CMD_TIME_RD, 8'h00, TIME_MAX);
    tick(6);
    cmd(CMD_TIME_RD, 8'h00, 16'h0000, 1'b0);
    chk1("time wrapped", 1'b1, host.got_data < 16'h0004);
    $display("t_time done");
  endtask

  // ----------------------------------------------------------
  // run control
  // ----------------------------------------------------------
  task automatic results;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // main sequence, inputs settle before the first edge
  initial begin
    reset = 1'b1;
    ar_cycle_done = '0;
    ar_initiator = 2'd3;
    ev_valid = 1'b0;
    ev_channel = 5'h00;
    ev_code = 6'h00;
    auto_reset_seen = 1'b0;
    btn_step = 1'b0;
    btn_up = 1'b0;
    display_on = 1'b0;
    nv_fail = 1'b0;
    tick(2);
    reset = 1'b0;
    t_power();
    t_count();
    t_store();
    t_inhibit();
    t_events();
    t_time();
    results();
  end

  // whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    $display("ERROR watchdog expected finish seen timeout");
    results();
  end
endmodule
`default_nettype wire

// *** bench/station_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module station_host
  import feeder_param_pkg::*;
(
  input wire logic clk_sys,
  output logic cmd_valid,
  output var cmd_t cmd_op,
  output logic [7:0] cmd_index,
  output logic [15:0] cmd_wdata,
  input wire logic rsp_valid,
  input wire logic rsp_error,
  input wire logic rsp_empty,
  input wire logic [15:0] rsp_data
);
  logic got_valid, got_error, got_empty;
  logic [15:0] got_data;

  // ----------------------------------------------------------
  // command issue
  // ----------------------------------------------------------
  // quiet until the bench asks for a command
  initial begin
    cmd_valid = 1'b0;
    cmd_op = CMD_PARAM_RD;
    cmd_index = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // one strobe, answer taken at the edge that follows it
  task automatic send(input cmd_t op, input logic [7:0] idx,
                      input logic [15:0] wd);
    @(posedge clk_sys);
    #1;
    cmd_valid = 1'b1;
    cmd_op = op; // event codes serve event transfer only
    cmd_index = idx;
    cmd_wdata = wd;
    @(posedge clk_sys);
    #1;
    got_valid = rsp_valid;
    got_error = rsp_error;
    got_empty = rsp_empty;
    got_data = rsp_data;
    cmd_valid = 1'b0;
    cmd_index = ~idx; // released index and data lines never keep the old value, cmd_op does
    cmd_wdata = ~wd;
  endtask
endmodule
`default_nettype wire

// *** core/feeder_param_access.sv ***
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - five cycles: read-only total and three writable initiator counts, 0..999
// - writing 1 to nv_store_command copies parameters to nonvolatile, about 5 s
// - default_reload_inhibit readable/writable: 0 allows reload on nonvolatile failure, 1 blocks it
// - event read returns time stamp, channel number and event code
// - each event register content is delivered only once by event read
// - event re-read returns the last delivered content, repeatable
// - status code: 0 normal, 1 auto reset, 2 overflow, 3 both
// - writing 0 to status clears reset and overflow indications
// - seconds time readable and writable, 0.000..59.999 s in ms
// - event, re-read, status and time codes only for event transfer
// - step and up held until display lights: load factory defaults
// - after reset default_reload_inhibit is 1
module feeder_param_access
  import feeder_param_pkg::*;
#(
  parameter int EV_DEPTH = 8,
  parameter int NV_CYCLES = NV_STORE_CYCLES,
  parameter int TICK_CYCLES = MS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire cmd_t cmd_op,
  input wire logic [7:0] cmd_index,
  input wire logic [15:0] cmd_wdata,
  input wire logic [N_AR_CYCLES-1:0] ar_cycle_done,
  input wire logic [1:0] ar_initiator,
  input wire logic ev_valid,
  input wire logic [4:0] ev_channel,
  input wire logic [5:0] ev_code,
  input wire logic auto_reset_seen,
  input wire logic btn_step,
  input wire logic btn_up,
  input wire logic display_on,
  input wire logic nv_fail,
  output logic rsp_valid,
  output logic rsp_error,
  output logic rsp_empty,
  output logic [15:0] rsp_data,
  output logic [15:0] rsp_time,
  output logic [4:0] rsp_channel,
  output logic [5:0] rsp_code,
  output logic nv_busy,
  output logic default_reload_inhibit,
  output logic defaults_loaded
);

  // ---------------------------------------------------------------
  // sizing and elaboration checks
  // ---------------------------------------------------------------
  localparam int N_CNT = N_AR_CYCLES * N_SLOTS;
  localparam int PW = $clog2(EV_DEPTH);
  localparam int CW = $clog2(EV_DEPTH + 1);
  localparam int NVW = $clog2(NV_CYCLES + 1);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int EW = 27;                    // time, channel, code

  generate
    if (EV_DEPTH < 2 || (EV_DEPTH & (EV_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("EV_DEPTH must be a power of two, at least 2");
    end
    if (NV_CYCLES < 1 || TICK_CYCLES < 1) begin : g_bad_time
      $error("NV_CYCLES and TICK_CYCLES must be at least 1");
    end
  endgenerate

  // maps a parameter index onto a counter slot, bit 5 flags a hit
  function automatic logic [5:0] cnt_slot(input logic [7:0] idx);
    logic [7:0] off;
    off = idx - IDX_CNT_BASE;
    if (idx >= IDX_CNT_BASE && off < 8'(N_CNT))
      cnt_slot = {1'b1, off[4:0]};
    else
      cnt_slot = 6'h00;
  endfunction

  // counters wrap past the top of their range
  function automatic logic [9:0] cnt_inc(input logic [9:0] v);
    cnt_inc = (v == CNT_MAX) ? CNT_RST : v + 10'h001;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [9:0] cnt_q [N_CNT];
  logic [9:0] cnt_d [N_CNT];
  logic [9:0] nv_cnt_q [N_CNT];
  logic [9:0] nv_cnt_d [N_CNT];
  logic [EW-1:0] ev_mem_q [EV_DEPTH];
  logic [EW-1:0] ev_mem_d [EV_DEPTH];
  logic [PW-1:0] ev_wr_q, ev_wr_d, ev_rd_q, ev_rd_d;
  logic [CW-1:0] ev_cnt_q, ev_cnt_d;
  logic [EW-1:0] last_q, last_d;
  logic last_ok_q, last_ok_d;
  logic ovf_q, ovf_d, arst_q, arst_d;
  logic inhibit_q, inhibit_d, nv_inhibit_q, nv_inhibit_d;
  logic [15:0] time_q, time_d;
  logic [TW-1:0] tick_q, tick_d;
  logic [NVW-1:0] nv_cnt_left_q, nv_cnt_left_d;
  nv_t nv_q, nv_d;
  pwr_t pwr_q, pwr_d;
  logic rv_q, rv_d, re_q, re_d, rm_q, rm_d, dl_q, dl_d;
  logic [15:0] rd_q, rd_d, rt_q, rt_d;
  logic [4:0] rc_q, rc_d;
  logic [5:0] rk_q, rk_d;

  logic [5:0] slot;
  logic tick, load_def, stat_clr, ev_pop, ev_push;

  // ---------------------------------------------------------------
  // next-state logic for everything but the status flags
  // ---------------------------------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    nv_cnt_d = nv_cnt_q;
    ev_mem_d = ev_mem_q;
    ev_wr_d = ev_wr_q;
    ev_rd_d = ev_rd_q;
    ev_cnt_d = ev_cnt_q;
    last_d = last_q;
    last_ok_d = last_ok_q;
    inhibit_d = inhibit_q;
    nv_inhibit_d = nv_inhibit_q;
    nv_d = nv_q;
    nv_cnt_left_d = nv_cnt_left_q;
    pwr_d = pwr_q;
    rv_d = cmd_valid;
    re_d = 1'b0;
    rm_d = 1'b0;
    rd_d = 16'h0000;
    rt_d = rt_q;
    rc_d = rc_q;
    rk_d = rk_q;
    dl_d = 1'b0;
    stat_clr = 1'b0;
    ev_pop = 1'b0;
    slot = cnt_slot(cmd_index);
    load_def = 1'b0;

    // millisecond time base, host set overrides the tick
    tick = (tick_q == TW'(TICK_CYCLES - 1));
    tick_d = tick ? '0 : tick_q + TW'(1);
    time_d = time_q;
    if (tick)
      time_d = (time_q == TIME_MAX) ? TIME_RST : time_q + 16'h0001;

    // auto-reclose cycle completions feed total and initiator counts
    for (int c = 0; c < N_AR_CYCLES; c++) begin
      if (ar_cycle_done[c]) begin
        cnt_d[c*N_SLOTS] = cnt_inc(cnt_q[c*N_SLOTS]);
        if (ar_initiator != 2'b11)
          cnt_d[c*N_SLOTS + int'(ar_initiator) + 1] =
            cnt_inc(cnt_q[c*N_SLOTS + int'(ar_initiator) + 1]);
      end
    end

    // nonvolatile store runs for its full duration once started
    if (nv_q == NV_BUSY) begin
      if (nv_cnt_left_q == NVW'(1)) begin
        nv_d = NV_IDLE;
        nv_cnt_d = cnt_q;
        nv_inhibit_d = inhibit_q;
      end
      nv_cnt_left_d = nv_cnt_left_q - NVW'(1);
    end

    // host commands; the event codes touch only event-side state
    if (cmd_valid) begin
      case (cmd_op)
        CMD_PARAM_RD: begin
          if (slot[5])
            rd_d = {6'h00, cnt_q[slot[4:0]]};
          else if (cmd_index == IDX_INHIBIT)
            rd_d = {15'h0000, inhibit_q};
          else
            re_d = 1'b1; // write-only or unmapped
        end
        CMD_PARAM_WR: begin
          if (slot[5] && slot[1:0] != 2'b00 && cmd_wdata <= 16'(CNT_MAX))
            cnt_d[slot[4:0]] = cmd_wdata[9:0];
          else if (cmd_index == IDX_INHIBIT && cmd_wdata[15:1] == 15'h0000)
            inhibit_d = cmd_wdata[0];
          else if (cmd_index == IDX_NV_STORE && cmd_wdata == NV_STORE_GO &&
                   nv_q == NV_IDLE) begin
            nv_d = NV_BUSY;
            nv_cnt_left_d = NVW'(NV_CYCLES);
          end else
            re_d = 1'b1; // totals are read-only, busy store refused
        end
        CMD_EV_READ: begin
          if (ev_cnt_q != '0) begin
            ev_pop = 1'b1;
            last_d = ev_mem_q[ev_rd_q];
            last_ok_d = 1'b1;
            {rt_d, rc_d, rk_d} = ev_mem_q[ev_rd_q];
            ev_rd_d = ev_rd_q + PW'(1);
          end else
            rm_d = 1'b1;
        end
        CMD_EV_REREAD: begin
          if (last_ok_q)
            {rt_d, rc_d, rk_d} = last_q;
          else
            rm_d = 1'b1;
        end
        CMD_STAT_RD: rd_d = {14'h0000, ovf_q, arst_q};
        CMD_STAT_WR: begin
          if (cmd_wdata == STAT_CLEAR)
            stat_clr = 1'b1;
          else
            re_d = 1'b1;
        end
        CMD_TIME_RD: rd_d = time_q;
        CMD_TIME_WR: begin
          if (cmd_wdata <= TIME_MAX) begin
            time_d = cmd_wdata;
            tick_d = '0;
          end else
            re_d = 1'b1;
        end
        default: re_d = 1'b1;
      endcase
    end

    // event capture, a full register drops the newcomer unless an event read frees a place in the same cycle
    ev_push = ev_valid && (ev_cnt_q != CW'(EV_DEPTH) || ev_pop);
    if (ev_push) begin
      ev_mem_d[ev_wr_q] = {time_q, ev_channel, ev_code};
      ev_wr_d = ev_wr_q + PW'(1);
    end
    ev_cnt_d = ev_cnt_q + CW'(ev_push) - CW'(ev_pop);

    // power-up button chord, or a nonvolatile failure when allowed
    if (pwr_q == PWR_WAIT && display_on) begin
      pwr_d = PWR_RUN;
      load_def = btn_step && btn_up;
    end
    if (nv_fail && !inhibit_q)
      load_def = 1'b1;
    if (load_def) begin
      for (int i = 0; i < N_CNT; i++)
        cnt_d[i] = CNT_RST;
      inhibit_d = INHIBIT_RST;
      dl_d = 1'b1;
    end
  end

  // sticky status flags; a new overflow or auto reset beats a clear in the same cycle
  assign ovf_d = (ev_valid && !ev_push) || (ovf_q && !stat_clr);
  assign arst_d = auto_reset_seen || (arst_q && !stat_clr);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < N_CNT; i++) begin
        cnt_q[i] <= CNT_RST;
        nv_cnt_q[i] <= CNT_RST;
      end
      for (int i = 0; i < EV_DEPTH; i++)
        ev_mem_q[i] <= '0;
      ev_wr_q <= '0;
      ev_rd_q <= '0;
      ev_cnt_q <= '0;
      last_q <= '0;
      last_ok_q <= 1'b0;
      ovf_q <= 1'b0;
      arst_q <= 1'b0;
      inhibit_q <= INHIBIT_RST;
      nv_inhibit_q <= INHIBIT_RST;
      time_q <= TIME_RST;
      tick_q <= '0;
      nv_cnt_left_q <= '0;
      nv_q <= NV_IDLE;
      pwr_q <= PWR_WAIT;
      rv_q <= 1'b0;
      re_q <= 1'b0;
      rm_q <= 1'b0;
      rd_q <= 16'h0000;
      rt_q <= 16'h0000;
      rc_q <= 5'h00;
      rk_q <= 6'h00;
      dl_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      nv_cnt_q <= nv_cnt_d;
      ev_mem_q <= ev_mem_d;
      ev_wr_q <= ev_wr_d;
      ev_rd_q <= ev_rd_d;
      ev_cnt_q <= ev_cnt_d;
      last_q <= last_d;
      last_ok_q <= last_ok_d;
      ovf_q <= ovf_d;
      arst_q <= arst_d;
      inhibit_q <= inhibit_d;
      nv_inhibit_q <= nv_inhibit_d;
      time_q <= time_d;
      tick_q <= tick_d;
      nv_cnt_left_q <= nv_cnt_left_d;
      nv_q <= nv_d;
      pwr_q <= pwr_d;
      rv_q <= rv_d;
      re_q <= re_d;
      rm_q <= rm_d;
      rd_q <= rd_d;
      rt_q <= rt_d;
      rc_q <= rc_d;
      rk_q <= rk_d;
      dl_q <= dl_d;
    end
  end

  // outputs straight from flops
  assign rsp_valid = rv_q;
  assign rsp_error = re_q;
  assign rsp_empty = rm_q;
  assign rsp_data = rd_q;
  assign rsp_time = rt_q;
  assign rsp_channel = rc_q;
  assign rsp_code = rk_q;
  assign nv_busy = (nv_q == NV_BUSY);
  assign default_reload_inhibit = inhibit_q;
  assign defaults_loaded = dl_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence seq_chord;
    pwr_q == PWR_WAIT && display_on && btn_step && btn_up;
  endsequence

  sequence seq_ev_take;
    cmd_valid && cmd_op == CMD_EV_READ && ev_cnt_q != '0 && !ev_valid;
  endsequence

  chk_total_counts: assert property (ar_cycle_done[0] && !cmd_valid &&
    !nv_fail && pwr_q == PWR_RUN && cnt_q[0] != CNT_MAX
    |=> cnt_q[0] == $past(cnt_q[0]) + 10'h001)
    else $error("total count did not advance");
  chk_store_busy: assert property (nv_q == NV_IDLE && cmd_valid &&
    cmd_op == CMD_PARAM_WR && cmd_index == IDX_NV_STORE &&
    cmd_wdata == NV_STORE_GO |=> nv_busy)
    else $error("store did not start");
  chk_inhibit_write: assert property (cmd_valid && cmd_op == CMD_PARAM_WR &&
    cmd_index == IDX_INHIBIT && cmd_wdata == 16'h0000 && !display_on &&
    !nv_fail
    |=> !default_reload_inhibit)
    else $error("inhibit write lost");
  chk_event_once: assert property (seq_ev_take
    |=> rsp_valid && !rsp_empty && ev_cnt_q == $past(ev_cnt_q) - CW'(1)
    ##1 last_ok_q)
    else $error("event read not consumed");
  chk_reread_same: assert property (cmd_valid && cmd_op == CMD_EV_REREAD &&
    last_ok_q |=> {rsp_time, rsp_channel, rsp_code} == $past(last_q))
    else $error("re-read returned other contents");
  chk_status_code: assert property (cmd_valid && cmd_op == CMD_STAT_RD
    |=> rsp_data == {14'h0000, $past(ovf_q), $past(arst_q)})
    else $error("status code mismatch");
  chk_status_clear: assert property (cmd_valid && cmd_op == CMD_STAT_WR &&
    cmd_wdata == STAT_CLEAR && !auto_reset_seen && !ev_valid
    |=> !ovf_q && !arst_q)
    else $error("status not cleared");
  chk_time_wrap: assert property (time_q == TIME_MAX && tick && !cmd_valid
    |=> time_q == TIME_RST)
    else $error("time did not wrap");
  chk_chord_load: assert property (seq_chord
    |=> defaults_loaded && default_reload_inhibit && cnt_q[1] == CNT_RST)
    else $error("defaults not loaded");
  chk_reset_inhibit: assert property (disable iff (1'b0)
    reset |=> default_reload_inhibit)
    else $error("inhibit not set by reset");

endmodule
`default_nettype wire

// *** pkg/feeder_param_pkg.sv ***
`default_nettype none
package feeder_param_pkg;

  // ---------------------------------------------------------------
  // host command set
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_PARAM_RD,
    CMD_PARAM_WR,
    CMD_EV_READ,
    CMD_EV_REREAD,
    CMD_STAT_RD,
    CMD_STAT_WR,
    CMD_TIME_RD,
    CMD_TIME_WR
  } cmd_t;

  // power-up and nonvolatile store sequencing
  typedef enum logic {PWR_WAIT, PWR_RUN} pwr_t;
  typedef enum logic {NV_IDLE, NV_BUSY} nv_t;

  // ---------------------------------------------------------------
  // parameter indices and field limits
  // ---------------------------------------------------------------
  localparam int N_AR_CYCLES = 5;
  localparam int N_SLOTS = 4;           // slot 0 total, 1..3 initiators
  localparam logic [7:0] IDX_CNT_BASE = 8'h14;  // first cycle total
  localparam logic [7:0] IDX_NV_STORE = 8'h97;
  localparam logic [7:0] IDX_INHIBIT = 8'h98;
  localparam logic [9:0] CNT_MAX = 10'h3e7;     // 999
  localparam logic [9:0] CNT_RST = 10'h000;
  localparam logic [15:0] TIME_MAX = 16'hea5f;  // 59.999 s in ms
  localparam logic [15:0] TIME_RST = 16'h0000;
  localparam logic INHIBIT_RST = 1'b1;          // reload inhibited
  localparam logic [15:0] NV_STORE_GO = 16'h0001;
  localparam logic [15:0] STAT_CLEAR = 16'h0000;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int NV_STORE_S = 5;
  localparam int NV_STORE_CYCLES = NV_STORE_S * CLK_HZ;
  localparam int TIME_RES_MS = 1;
  localparam int MS_CYCLES = (CLK_HZ / 1000) * TIME_RES_MS;

endpackage
`default_nettype wire
